// >>> shared/stx_pkg.sv
// constants and types shared by the skip, table-read and xor execution unit
`default_nettype none
package stx_pkg;

    // ------------------------------------------------------------
    // widths
    // ------------------------------------------------------------
    localparam int DATA_W   = 8;
    localparam int NIB_W    = 4;
    localparam int BIT_W    = 3;
    localparam int ROM_W    = 16;
    localparam int ROM_AW   = 12;
    localparam int PAGE_W   = ROM_AW - DATA_W;
    localparam int OPC_W    = 4;

    // ------------------------------------------------------------
    // values
    // ------------------------------------------------------------
    localparam logic [DATA_W-1:0] BYTE_ZERO = 8'h00;
    localparam logic [PAGE_W-1:0] LAST_PAGE = {PAGE_W{1'b1}};
    localparam logic [DATA_W-1:0] ACC_RST   = 8'h00;

    // ------------------------------------------------------------
    // instruction kinds handled by this unit
    // ------------------------------------------------------------
    typedef enum logic [OPC_W-1:0] {
        OP_NONE                    = 4'h0,
        OP_NIBBLE_SWAP_TO_ACC      = 4'h1,
        OP_SKIP_IF_ZERO            = 4'h2,
        OP_MOVE_SKIP_IF_ZERO       = 4'h3,
        OP_SKIP_BIT_CLEAR          = 4'h4,
        OP_TABLE_READ_CURRENT_PAGE = 4'h5,
        OP_TABLE_READ_LAST_PAGE    = 4'h6,
        OP_XOR_TO_ACC              = 4'h7,
        OP_XOR_TO_MEMORY           = 4'h8,
        OP_XOR_IMMEDIATE           = 4'h9
    } stx_op_t;

    // one-hot execution states
    typedef enum logic [2:0] {
        ST_IDLE  = 3'h1,
        ST_DUMMY = 3'h2,
        ST_TABLE = 3'h4
    } stx_state_t;

endpackage
`default_nettype wire

// >>> shared/stx_alu_if.sv
// operand and result bundle between the execution control and its data path
`timescale 1ns/100ps
`default_nettype none
interface stx_alu_if;
    stx_pkg::stx_op_t                 opc;
    logic [stx_pkg::DATA_W-1:0]       acc;
    logic [stx_pkg::DATA_W-1:0]       mem;
    logic [stx_pkg::DATA_W-1:0]       imm;
    logic [stx_pkg::BIT_W-1:0]        bit_sel;
    logic [stx_pkg::DATA_W-1:0]       result;
    logic                             zero;
    logic                             skip;
    logic                             wr_acc;
    logic                             wr_mem;
    logic                             wr_zero;

    modport ctrl (output opc, acc, mem, imm, bit_sel,
                  input  result, zero, skip, wr_acc, wr_mem, wr_zero);
    modport path (input  opc, acc, mem, imm, bit_sel,
                  output result, zero, skip, wr_acc, wr_mem, wr_zero);
endinterface
`default_nettype wire

// >>> hdl/stx_alu.sv
// combinational data path: nibble swap, zero tests and exclusive-or
`timescale 1ns/100ps
`default_nettype none
module stx_alu (
    stx_alu_if.path bus
);
    logic [stx_pkg::DATA_W-1:0] swapped;

    // ------------------------------------------------------------
    // nibble swap, one generate pass per nibble
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < stx_pkg::DATA_W / stx_pkg::NIB_W; g++) begin : g_nib
            localparam int SRC = (stx_pkg::DATA_W / stx_pkg::NIB_W) - 1 - g;
            assign swapped[g*stx_pkg::NIB_W +: stx_pkg::NIB_W] =
                bus.mem[SRC*stx_pkg::NIB_W +: stx_pkg::NIB_W];
        end
    endgenerate

    // ------------------------------------------------------------
    // operation select
    // ------------------------------------------------------------
    always_comb begin
        bus.result  = bus.acc;
        bus.skip    = 1'b0;
        bus.wr_acc  = 1'b0;
        bus.wr_mem  = 1'b0;
        bus.wr_zero = 1'b0;
        unique case (bus.opc)
            stx_pkg::OP_NIBBLE_SWAP_TO_ACC: begin
                bus.result = swapped;
                bus.wr_acc = 1'b1;
            end
            stx_pkg::OP_SKIP_IF_ZERO: begin
                bus.skip = (bus.mem == stx_pkg::BYTE_ZERO);
            end
            stx_pkg::OP_MOVE_SKIP_IF_ZERO: begin
                bus.result = bus.mem;
                bus.wr_acc = 1'b1;
                bus.skip   = (bus.mem == stx_pkg::BYTE_ZERO);
            end
            stx_pkg::OP_SKIP_BIT_CLEAR: begin
                bus.skip = ~bus.mem[bus.bit_sel];
            end
            stx_pkg::OP_XOR_TO_ACC: begin
                bus.result  = bus.acc ^ bus.mem;
                bus.wr_acc  = 1'b1;
                bus.wr_zero = 1'b1;
            end
            stx_pkg::OP_XOR_TO_MEMORY: begin
                bus.result  = bus.mem ^ bus.acc;
                bus.wr_mem  = 1'b1;
                bus.wr_zero = 1'b1;
            end
            stx_pkg::OP_XOR_IMMEDIATE: begin
                bus.result  = bus.acc ^ bus.imm;
                bus.wr_acc  = 1'b1;
                bus.wr_zero = 1'b1;
            end
            default: begin
                bus.result = bus.acc;
            end
        endcase
        bus.zero = (bus.result == stx_pkg::BYTE_ZERO);
    end
endmodule
`default_nettype wire

// >>> hdl/stx_exec.sv
// execution unit for skip, table-read, nibble-swap and xor instructions
// Functional notes
// - swap nibbles of byte into accumulator only
// - zero byte: discard next, dummy cycle
// - copy byte to accumulator, skip if zero
// - selected bit clear: skip with dummy cycle
// - table read current page: low byte, high latch
// - table read last page: low byte, high latch
// - accumulator xor byte into accumulator, zero flag
// - byte xor accumulator into byte, zero flag
// - accumulator xor constant into accumulator, zero flag
`timescale 1ns/100ps
`default_nettype none
module stx_exec (
    input  wire logic                           clk,
    input  wire logic                           rst,
    input  wire logic                           op_valid,
    input  wire stx_pkg::stx_op_t               op_code,
    input  wire logic [stx_pkg::BIT_W-1:0]      op_bit,
    input  wire logic [stx_pkg::DATA_W-1:0]     op_imm,
    input  wire logic [stx_pkg::DATA_W-1:0]     mem_rdata,
    input  wire logic [stx_pkg::DATA_W-1:0]     table_pointer,
    input  wire logic [stx_pkg::PAGE_W-1:0]     pc_page,
    input  wire logic [stx_pkg::ROM_W-1:0]      rom_word,
    output logic                                busy,
    output logic                                discard,
    output logic                                rom_rd,
    output logic [stx_pkg::ROM_AW-1:0]          rom_addr,
    output logic                                mem_we,
    output logic [stx_pkg::DATA_W-1:0]          mem_wdata,
    output logic [stx_pkg::DATA_W-1:0]          acc,
    output logic                                zero_flag,
    output logic [stx_pkg::DATA_W-1:0]          table_high_latch
);
    localparam int LO = stx_pkg::DATA_W;

    function automatic logic is_table(input stx_pkg::stx_op_t op);
        return (op == stx_pkg::OP_TABLE_READ_CURRENT_PAGE) ||
               (op == stx_pkg::OP_TABLE_READ_LAST_PAGE);
    endfunction

    stx_alu_if alu_bus ();

    stx_pkg::stx_state_t                state;
    stx_pkg::stx_state_t                next_state;
    logic                               take;
    logic                               next_busy;
    logic                               next_discard;
    logic                               next_rom_rd;
    logic [stx_pkg::ROM_AW-1:0]         next_rom_addr;
    logic                               next_mem_we;
    logic [stx_pkg::DATA_W-1:0]         next_mem_wdata;
    logic [stx_pkg::DATA_W-1:0]         next_acc;
    logic                               next_zero_flag;
    logic [stx_pkg::DATA_W-1:0]         next_table_high_latch;

    // ------------------------------------------------------------
    // data path
    // ------------------------------------------------------------
    assign alu_bus.opc     = op_code;
    assign alu_bus.acc     = acc;
    assign alu_bus.mem     = mem_rdata;
    assign alu_bus.imm     = op_imm;
    assign alu_bus.bit_sel = op_bit;

    stx_alu u_alu (
        .bus (alu_bus.path)
    );

    // new instructions are refused during dummy and table fetch cycles
    assign take = op_valid && (state == stx_pkg::ST_IDLE);

    // ------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------
    always_comb begin
        next_state            = stx_pkg::ST_IDLE;
        next_discard          = 1'b0;
        next_rom_rd           = 1'b0;
        next_rom_addr         = rom_addr;
        next_mem_we           = 1'b0;
        next_mem_wdata        = mem_wdata;
        next_acc              = acc;
        next_zero_flag        = zero_flag;
        next_table_high_latch = table_high_latch;
        unique case (state)
            stx_pkg::ST_IDLE: begin
                if (take && is_table(op_code)) begin
                    next_state  = stx_pkg::ST_TABLE;
                    next_rom_rd = 1'b1;
                    if (op_code == stx_pkg::OP_TABLE_READ_LAST_PAGE) begin
                        next_rom_addr = {stx_pkg::LAST_PAGE, table_pointer};
                    end else begin
                        next_rom_addr = {pc_page, table_pointer};
                    end
                end else if (take) begin
                    if (alu_bus.skip) begin
                        next_state   = stx_pkg::ST_DUMMY;
                        next_discard = 1'b1;
                    end
                    if (alu_bus.wr_acc) begin
                        next_acc = alu_bus.result;
                    end
                    if (alu_bus.wr_mem) begin
                        next_mem_we    = 1'b1;
                        next_mem_wdata = alu_bus.result;
                    end
                    if (alu_bus.wr_zero) begin
                        next_zero_flag = alu_bus.zero;
                    end
                end
            end
            stx_pkg::ST_DUMMY: begin
                next_state = stx_pkg::ST_IDLE;
            end
            stx_pkg::ST_TABLE: begin
                next_mem_we           = 1'b1;
                next_mem_wdata        = rom_word[LO-1:0];
                next_table_high_latch = rom_word[stx_pkg::ROM_W-1:LO];
            end
            default: begin
                next_state = stx_pkg::ST_IDLE;
            end
        endcase
        next_busy = (next_state != stx_pkg::ST_IDLE);
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            state            <= stx_pkg::ST_IDLE;
            busy             <= 1'b0;
            discard          <= 1'b0;
            rom_rd           <= 1'b0;
            rom_addr         <= '0;
            mem_we           <= 1'b0;
            mem_wdata        <= stx_pkg::BYTE_ZERO;
            acc              <= stx_pkg::ACC_RST;
            zero_flag        <= 1'b0;
            table_high_latch <= stx_pkg::BYTE_ZERO;
        end else begin
            state            <= next_state;
            busy             <= next_busy;
            discard          <= next_discard;
            rom_rd           <= next_rom_rd;
            rom_addr         <= next_rom_addr;
            mem_we           <= next_mem_we;
            mem_wdata        <= next_mem_wdata;
            acc              <= next_acc;
            zero_flag        <= next_zero_flag;
            table_high_latch <= next_table_high_latch;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence dummy_then_free_s;
        discard && busy ##1 !busy && !discard;
    endsequence

    sequence table_fetch_s(logic [stx_pkg::PAGE_W-1:0] pg);
        rom_rd && busy && rom_addr == {pg, $past(table_pointer)}
        ##1 mem_we && !busy && mem_wdata == $past(rom_word[LO-1:0])
            && table_high_latch == $past(rom_word[stx_pkg::ROM_W-1:LO]);
    endsequence

    swap_to_acc_a: assert property (
        take && op_code == stx_pkg::OP_NIBBLE_SWAP_TO_ACC |=>
        acc == {$past(mem_rdata[stx_pkg::NIB_W-1:0]),
                $past(mem_rdata[stx_pkg::DATA_W-1:stx_pkg::NIB_W])} && !mem_we)
        else $error("nibble swap into accumulator wrong");

    zero_byte_skip_a: assert property (
        take && op_code == stx_pkg::OP_SKIP_IF_ZERO && mem_rdata == stx_pkg::BYTE_ZERO
        |=> dummy_then_free_s)
        else $error("zero byte did not skip with one dummy cycle");

    nonzero_run_a: assert property (
        take && op_code == stx_pkg::OP_SKIP_IF_ZERO && mem_rdata != stx_pkg::BYTE_ZERO
        |=> !discard && !busy)
        else $error("nonzero byte caused a skip");

    move_skip_a: assert property (
        take && op_code == stx_pkg::OP_MOVE_SKIP_IF_ZERO |=>
        acc == $past(mem_rdata) && discard == ($past(mem_rdata) == stx_pkg::BYTE_ZERO))
        else $error("move and skip wrong");

    bit_skip_a: assert property (
        take && op_code == stx_pkg::OP_SKIP_BIT_CLEAR |=>
        discard == !$past(mem_rdata[op_bit]) && busy == discard)
        else $error("bit test skip wrong");

    table_cur_a: assert property (
        take && op_code == stx_pkg::OP_TABLE_READ_CURRENT_PAGE |=>
        table_fetch_s($past(pc_page)))
        else $error("current page table read wrong");

    table_last_a: assert property (
        take && op_code == stx_pkg::OP_TABLE_READ_LAST_PAGE |=>
        table_fetch_s(stx_pkg::LAST_PAGE))
        else $error("last page table read wrong");

    xor_acc_a: assert property (
        take && op_code == stx_pkg::OP_XOR_TO_ACC |=>
        acc == ($past(acc) ^ $past(mem_rdata)) && !mem_we)
        else $error("xor into accumulator wrong");

    xor_mem_a: assert property (
        take && op_code == stx_pkg::OP_XOR_TO_MEMORY |=>
        mem_we && mem_wdata == ($past(acc) ^ $past(mem_rdata)) && $stable(acc))
        else $error("xor into memory wrong");

    xor_imm_a: assert property (
        take && op_code == stx_pkg::OP_XOR_IMMEDIATE |=>
        acc == ($past(acc) ^ $past(op_imm)))
        else $error("xor immediate wrong");

    flags_kept_a: assert property (
        !(take && (op_code == stx_pkg::OP_XOR_TO_ACC ||
                   op_code == stx_pkg::OP_XOR_IMMEDIATE ||
                   op_code == stx_pkg::OP_XOR_TO_MEMORY)) |=> $stable(zero_flag))
        else $error("zero flag changed by non xor op");

    zero_meaning_a: assert property (
        take && (op_code == stx_pkg::OP_XOR_TO_ACC || op_code == stx_pkg::OP_XOR_IMMEDIATE)
        |=> zero_flag == (acc == stx_pkg::BYTE_ZERO))
        else $error("zero flag does not match result");

    zero_mem_a: assert property (
        take && op_code == stx_pkg::OP_XOR_TO_MEMORY
        |=> zero_flag == (mem_wdata == stx_pkg::BYTE_ZERO))
        else $error("zero flag does not match memory result");
endmodule
`default_nettype wire

// >>> tb/skip_table_xor_exec_test.sv
// self-checking bench for the skip, table-read, swap and xor execution unit
`timescale 1ns/100ps
`default_nettype none
module skip_table_xor_exec_test;

    // ------------------------------------------------------------
    // signals and expected-result notes
    // ------------------------------------------------------------
    typedef struct {
        int          cyc;
        logic        busy;
        logic        discard;
        logic        rom_rd;
        logic        mem_we;
        logic        zero;
        logic [7:0]  acc;
        logic [7:0]  wdata;
        logic [7:0]  latch;
        logic [11:0] addr;
    } stx_note_t;

    logic              clk;
    logic              rst;
    logic              op_valid;
    stx_pkg::stx_op_t  op_code;
    logic [2:0]        op_bit;
    logic [7:0]        op_imm;
    logic [7:0]        mem_rdata;
    logic [7:0]        table_pointer;
    logic [3:0]        pc_page;
    logic [15:0]       rom_word;
    logic              busy;
    logic              discard;
    logic              rom_rd;
    logic [11:0]       rom_addr;
    logic              mem_we;
    logic [7:0]        mem_wdata;
    logic [7:0]        acc;
    logic              zero_flag;
    logic [7:0]        table_high_latch;
    stx_note_t         notes[$];
    int                cyc;
    int                errors;
    int                n_compared;
    logic [7:0]        m_acc;
    logic [7:0]        m_wdata;
    logic [7:0]        m_latch;
    logic [11:0]       m_addr;
    logic              m_zero;

    stx_exec uut (
        .clk              (clk),
        .rst              (rst),
        .op_valid         (op_valid),
        .op_code          (op_code),
        .op_bit           (op_bit),
        .op_imm           (op_imm),
        .mem_rdata        (mem_rdata),
        .table_pointer    (table_pointer),
        .pc_page          (pc_page),
        .rom_word         (rom_word),
        .busy             (busy),
        .discard          (discard),
        .rom_rd           (rom_rd),
        .rom_addr         (rom_addr),
        .mem_we           (mem_we),
        .mem_wdata        (mem_wdata),
        .acc              (acc),
        .zero_flag        (zero_flag),
        .table_high_latch (table_high_latch)
    );

    always #20 clk = ~clk;

    always @(posedge clk) begin
        cyc <= cyc + 1;
    end

    // ------------------------------------------------------------
    // checking and closing
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic close_out();
        if (errors == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // outputs are settled at the falling edge
    always @(negedge clk) begin
        while (notes.size() > 0 && notes[0].cyc <= cyc) begin
            stx_note_t n;
            n = notes.pop_front();
            check({busy, discard}, {n.busy, n.discard});
            check({rom_rd, mem_we}, {n.rom_rd, n.mem_we});
            check(acc, n.acc);
            check(zero_flag, n.zero);
            check(mem_wdata, n.wdata);
            check({table_high_latch, rom_addr}, {n.latch, n.addr});
        end
    end

    // ------------------------------------------------------------
    // driver with reference model
    // ------------------------------------------------------------
    task automatic push(input int c, input logic bz, input logic dc, input logic rr,
                        input logic we);
        stx_note_t n;
        n = '{c, bz, dc, rr, we, m_zero, m_acc, m_wdata, m_latch, m_addr};
        notes.push_back(n);
    endtask

    task automatic run_op(input stx_pkg::stx_op_t op, input logic [7:0] m, input logic [7:0] imm,
                          input logic [7:0] ptr, input logic [2:0] b, input logic [3:0] pg,
                          input logic [15:0] rw);
        logic skip;
        logic tbl;
        logic we;
        int   c;
        skip = 1'b0;
        tbl = 1'b0;
        we = 1'b0;
        c = cyc;
        op_valid = 1'b1;
        op_code = op;
        mem_rdata = m;
        op_bit = b;
        op_imm = imm;
        table_pointer = ptr;
        pc_page = pg;
        case (op)
            stx_pkg::OP_NIBBLE_SWAP_TO_ACC:      m_acc = {m[3:0], m[7:4]};
            stx_pkg::OP_SKIP_IF_ZERO:            skip = (m == 8'h00);
            stx_pkg::OP_MOVE_SKIP_IF_ZERO: begin
                m_acc = m;
                skip = (m == 8'h00);
            end
            stx_pkg::OP_SKIP_BIT_CLEAR:          skip = ~m[b];
            stx_pkg::OP_TABLE_READ_CURRENT_PAGE: tbl = 1'b1;
            stx_pkg::OP_TABLE_READ_LAST_PAGE:    tbl = 1'b1;
            stx_pkg::OP_XOR_TO_ACC: begin
                m_acc = m_acc ^ m;
                m_zero = (m_acc == 8'h00);
            end
            stx_pkg::OP_XOR_TO_MEMORY: begin
                m_wdata = m_acc ^ m;
                m_zero = (m_wdata == 8'h00);
                we = 1'b1;
            end
            stx_pkg::OP_XOR_IMMEDIATE: begin
                m_acc = m_acc ^ imm;
                m_zero = (m_acc == 8'h00);
            end
            default: ;
        endcase
        if (tbl) begin
            m_addr = {pg, ptr};
            if (op == stx_pkg::OP_TABLE_READ_LAST_PAGE) begin
                m_addr = {stx_pkg::LAST_PAGE, ptr};
            end
            push(c + 1, 1'b1, 1'b0, 1'b1, 1'b0);
            m_wdata = rw[7:0];
            m_latch = rw[15:8];
            push(c + 2, 1'b0, 1'b0, 1'b0, 1'b1);
        end else begin
            push(c + 1, skip, skip, 1'b0, we);
            if (skip) begin
                push(c + 2, 1'b0, 1'b0, 1'b0, 1'b0);
            end
        end
        @(posedge clk) #1;
        if (skip || tbl) begin
            // a request during the busy cycle must be ignored
            op_code = stx_pkg::OP_XOR_IMMEDIATE;
            op_imm = 8'h5a;
            if (tbl) begin
                rom_word = rw;
            end
            @(posedge clk) #1;
            if (tbl) begin
                rom_word = ~rw;
            end
        end
    endtask

    // ------------------------------------------------------------
    // main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        rst = 1'b1;
        op_valid = 1'b0;
        op_code = stx_pkg::OP_NONE;
        op_bit = 3'h0;
        op_imm = 8'h00;
        mem_rdata = 8'h00;
        table_pointer = 8'h00;
        pc_page = 4'h0;
        rom_word = 16'h0000;
        cyc = 0;
        errors = 0;
        n_compared = 0;
        m_acc = stx_pkg::ACC_RST;
        m_wdata = 8'h00;
        m_latch = 8'h00;
        m_addr = 12'h000;
        m_zero = 1'b0;
        void'($urandom(31));
        repeat (10) @(posedge clk);
        #1;
        rst = 1'b0;
        push(cyc, 1'b0, 1'b0, 1'b0, 1'b0);
        run_op(stx_pkg::OP_SKIP_IF_ZERO, 8'h00, 8'h00, 8'h00, 3'h0, 4'h0, 16'h0000);
        run_op(stx_pkg::OP_SKIP_IF_ZERO, 8'h80, 8'h00, 8'h00, 3'h0, 4'h0, 16'h0000);
        run_op(stx_pkg::OP_MOVE_SKIP_IF_ZERO, 8'h00, 8'h00, 8'h00, 3'h0, 4'h0, 16'h0000);
        run_op(stx_pkg::OP_MOVE_SKIP_IF_ZERO, 8'h01, 8'h00, 8'h00, 3'h0, 4'h0, 16'h0000);
        for (int b = 0; b < 8; b++) begin
            run_op(stx_pkg::OP_SKIP_BIT_CLEAR, 8'h01 << b, 8'h00, 8'h00, 3'(b), 4'h0, 16'h0000);
            run_op(stx_pkg::OP_SKIP_BIT_CLEAR, ~(8'h01 << b), 8'h00, 8'h00, 3'(b), 4'h0, 16'h0000);
        end
        run_op(stx_pkg::OP_NIBBLE_SWAP_TO_ACC, 8'ha5, 8'h00, 8'h00, 3'h0, 4'h0, 16'h0000);
        run_op(stx_pkg::OP_XOR_IMMEDIATE, 8'h00, m_acc, 8'h00, 3'h0, 4'h0, 16'h0000);
        run_op(stx_pkg::OP_XOR_TO_ACC, 8'h3c, 8'h00, 8'h00, 3'h0, 4'h0, 16'h0000);
        run_op(stx_pkg::OP_XOR_TO_MEMORY, m_acc, 8'h00, 8'h00, 3'h0, 4'h0, 16'h0000);
        run_op(stx_pkg::OP_TABLE_READ_LAST_PAGE, 8'h00, 8'h00, 8'hff, 3'h0, 4'h3, 16'hbe7a);
        run_op(stx_pkg::OP_TABLE_READ_CURRENT_PAGE, 8'h00, 8'h00, 8'h00, 3'h0, 4'h3, 16'h7e15);
        for (int i = 0; i < 300; i++) begin
            run_op(stx_pkg::stx_op_t'(4'($urandom_range(9, 0))), 8'($urandom), 8'($urandom),
                   8'($urandom), 3'($urandom), 4'($urandom), 16'($urandom));
        end
        op_valid = 1'b0;
        repeat (3) @(posedge clk);
        close_out();
    end

    initial begin
        repeat (5000) @(posedge clk);
        errors++;
        close_out();
    end

endmodule
`default_nettype wire
